//--- verilog/fps_pkg.sv
// Shared constants and types for the fault protection sequencer
package fps_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Times as specified and their cycle counts; least times round up
    localparam int FDR_TIME_MS = 1500;
    localparam int INPUT_OVERVOLTAGE_FAULT_TIME_US = 750;
    localparam int NTC_TIME_US = 50;
    localparam int FDR_CYCLES =
        (FDR_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INPUT_OVERVOLTAGE_FAULT_CYCLES =
        (INPUT_OVERVOLTAGE_FAULT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NTC_CYCLES =
        (NTC_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Consecutive-pulse counts
    localparam int OVP_PULSES = 3;
    localparam int CSOTP_CYCLES = 2;

    // Register map
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Status field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_OVP = 3;
    localparam int STAT_INPUT_OVERVOLTAGE_FAULT = 4;
    localparam int STAT_FLTOTP = 5;
    localparam int STAT_CSOTP = 6;
    localparam int STAT_THRESH = 7;
    localparam int STAT_RUN = 8;

    typedef enum logic [2:0] {
        MODE_HEAVY = 3'h0,
        MODE_ADAPT_BURST = 3'h1,
        MODE_LOW_POWER = 3'h2,
        MODE_STANDBY_ONE = 3'h3,
        MODE_STANDBY_TWO = 3'h4
    } fps_mode_type;

    typedef struct packed {
        logic latchCsOtp;
        logic latchFltOtp;
        logic latchOvp;
        logic [2:0] mode;
    } fps_ctrl_type;

    // Comparator and supply monitor levels, all asynchronous to clk_sys
    typedef struct packed {
        logic auxOverVolt;
        logic iovpHigh;
        logic iovpBelowRelease;
        logic fltAboveBiasCut;
        logic fltBelowNtc;
        logic csAboveOtp;
        logic supplyOn;
        logic supplyOff;
        logic supplyBelowReset;
        logic lineZeroCross;
    } fps_sense_type;

    typedef enum logic [2:0] {
        ST_WAIT_ON = 3'h0,
        ST_CHECK = 3'h1,
        ST_RUN = 3'h3,
        ST_DELAY = 3'h2,
        ST_WAIT_FALL = 3'h6,
        ST_STOP = 3'h7,
        ST_LATCH = 3'h5
    } fps_state_type;

endpackage

//--- verilog/fps_level_timer.sv
// Qualifies a level that must hold for a number of cycles
`timescale 1ns/10ps
`default_nettype none
module fps_level_timer #(
    parameter int Count = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Level under qualification
    input wire logic level,
    // One-cycle pulse when the level has held Count cycles
    output logic fire_q
);
    localparam int CntW = $clog2(Count + 1);
    logic [CntW-1:0] cnt_q;

    // Saturates so a held level fires only once
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= '0;
            fire_q <= 1'h0;
        end
        else
        begin
            fire_q <= level && (cnt_q == CntW'(Count - 1));
            if (!level)
                cnt_q <= '0;
            else if (cnt_q != CntW'(Count))
                cnt_q <= cnt_q + CntW'(1);
        end
    end
endmodule
`default_nettype wire

//--- verilog/fps_run_counter.sv
// Counts consecutive positive samples and fires on the Nth
`timescale 1ns/10ps
`default_nettype none
module fps_run_counter #(
    parameter int Need = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Sample strobe, sampled condition, synchronous clear
    input wire logic sample,
    input wire logic hit,
    input wire logic clear,
    // One-cycle pulse on the Nth consecutive hit
    output logic fire_q
);
    localparam int CntW = $clog2(Need + 1);
    logic [CntW-1:0] cnt_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= '0;
            fire_q <= 1'h0;
        end
        else
        begin
            fire_q <= !clear && sample && hit &&
                (cnt_q == CntW'(Need - 1));
            if (clear || (sample && !hit))
                cnt_q <= '0;
            else if (sample && hit)
                cnt_q <= (cnt_q == CntW'(Need - 1)) ? '0 : cnt_q + CntW'(1);
        end
    end
endmodule
`default_nettype wire

//--- verilog/fps_fault_sequencer.sv
// Fault qualification and recovery sequencer for a flyback controller
`timescale 1ns/10ps
`default_nettype none
module fps_fault_sequencer #(
    parameter int FdrCycles = fps_pkg::FDR_CYCLES,
    parameter int IovpCycles = fps_pkg::INPUT_OVERVOLTAGE_FAULT_CYCLES,
    parameter int NtcCycles = fps_pkg::NTC_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Comparator and supply monitor levels from the analog side
    input wire fps_pkg::fps_sense_type sense,
    // Modulator requests and timing on clk_sys
    input wire logic lowSideReq,
    input wire logic highSideReq,
    input wire logic demagEnd,
    input wire logic burstOff,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData_q,
    // Gate drives and run
    output logic lowSideDrive_q,
    output logic highSideDrive_q,
    output logic runOut_q,
    // Analog controls
    output logic fltBiasEn_q,
    output logic ntcThreshHigh_q,
    output logic supplyRestart_q
);
    import fps_pkg::*;

    fps_sense_type senseMeta_q;
    fps_sense_type senseSync_q;
    fps_sense_type sensePrev_q;
    fps_ctrl_type ctrl_q;
    fps_state_type state_q;
    logic ovpFault_q;
    logic iovpFault_q;
    logic fltOtp_q;
    logic csOtp_q;
    logic csSeen_q;
    logic ovpTrip;
    logic csTrip;
    logic iovpTrip;
    logic ntcTrip;
    logic fdrDone;
    logic supplyFallEvt;
    logic latchReset;
    logic lightLoad;
    logic lowPowerMode;
    logic anyFault;
    logic switchOk;
    logic inRun;

    // Two-stage synchronisers; logic uses the second stage and its one-cycle delayed copy for edges
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            senseMeta_q <= '0;
            senseSync_q <= '0;
            sensePrev_q <= '0;
        end
        else
        begin
            senseMeta_q <= sense;
            senseSync_q <= senseMeta_q;
            sensePrev_q <= senseSync_q;
        end
    end

    assign supplyFallEvt = senseSync_q.supplyOff && !sensePrev_q.supplyOff;
    assign latchReset = senseSync_q.supplyBelowReset ||
        (senseSync_q.lineZeroCross && !sensePrev_q.lineZeroCross);
    assign lightLoad = ctrl_q.mode != MODE_HEAVY;
    assign lowPowerMode = ctrl_q.mode >= MODE_LOW_POWER;
    assign anyFault = ovpFault_q || iovpFault_q || fltOtp_q || csOtp_q;
    assign inRun = state_q == ST_RUN;
    assign switchOk = inRun && !anyFault;

    // Register port
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= fps_ctrl_type'(CTRL_RESET);
        else if (regWr && regAddr == CTRL_ADDR)
            ctrl_q <= fps_ctrl_type'(regWrData[CTRL_W-1:0]);
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            regRdData_q <= 32'h0000_0000;
        else if (regRd && regAddr == CTRL_ADDR)
            regRdData_q <= {26'h0, ctrl_q};
        else if (regRd && regAddr == STATUS_ADDR)
        begin
            regRdData_q <= 32'h0000_0000;
            regRdData_q[STAT_STATE_LSB +: 3] <= state_q;
            regRdData_q[STAT_OVP] <= ovpFault_q;
            regRdData_q[STAT_INPUT_OVERVOLTAGE_FAULT] <= iovpFault_q;
            regRdData_q[STAT_FLTOTP] <= fltOtp_q;
            regRdData_q[STAT_CSOTP] <= csOtp_q;
            regRdData_q[STAT_THRESH] <= ntcThreshHigh_q;
            regRdData_q[STAT_RUN] <= runOut_q;
        end
        else
            regRdData_q <= 32'h0000_0000;
    end

    // Output over-voltage: one sample per switching cycle at demag end
    fps_run_counter #(.Need(OVP_PULSES)) uOvpCount (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .sample(demagEnd),
        .hit(senseSync_q.auxOverVolt),
        .clear(!inRun),
        .fire_q(ovpTrip)
    );

    // Current-sense thermal: comparator seen between low-side off and
    // demag end; the low-side on time carries the real current signal
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            csSeen_q <= 1'h0;
        else if (demagEnd || lowSideDrive_q)
            csSeen_q <= 1'h0;
        else if (senseSync_q.csAboveOtp)
            csSeen_q <= 1'h1;
    end

    fps_run_counter #(.Need(CSOTP_CYCLES)) uCsCount (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .sample(demagEnd),
        .hit(csSeen_q),
        .clear(!inRun),
        .fire_q(csTrip)
    );

    // Input over-voltage timer is not gated by any state
    fps_level_timer #(.Count(IovpCycles)) uIovpTimer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .level(senseSync_q.iovpHigh),
        .fire_q(iovpTrip)
    );

    // Thermistor only valid while its bias current flows
    fps_level_timer #(.Count(NtcCycles)) uNtcTimer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .level(senseSync_q.fltBelowNtc && fltBiasEn_q && runOut_q),
        .fire_q(ntcTrip)
    );

    fps_level_timer #(.Count(FdrCycles)) uFdrTimer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .level(state_q == ST_DELAY),
        .fire_q(fdrDone)
    );

    // Fault flags; a set in the same cycle as a clear wins
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            ovpFault_q <= 1'h0;
        else if (ovpTrip)
            ovpFault_q <= 1'h1;
        else if (state_q == ST_WAIT_ON)
            ovpFault_q <= 1'h0;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            csOtp_q <= 1'h0;
        else if (csTrip)
            csOtp_q <= 1'h1;
        else if (state_q == ST_WAIT_ON)
            csOtp_q <= 1'h0;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            iovpFault_q <= 1'h0;
        else if (iovpTrip)
            iovpFault_q <= 1'h1;
        else if (senseSync_q.iovpBelowRelease)
            iovpFault_q <= 1'h0;
    end

    // Auto mode clears once the pin is back above the raised threshold
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            fltOtp_q <= 1'h0;
        else if (ntcTrip)
            fltOtp_q <= 1'h1;
        else if (ctrl_q.latchFltOtp ? (state_q == ST_LATCH && latchReset)
                : !senseSync_q.fltBelowNtc)
            fltOtp_q <= 1'h0;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            ntcThreshHigh_q <= 1'h0;
        else
            ntcThreshHigh_q <= (fltOtp_q || ntcTrip) &&
                !ctrl_q.latchFltOtp;
    end

    // Sequencer
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= ST_WAIT_ON;
        else
        begin
            unique case (state_q)
                ST_WAIT_ON:
                    if (senseSync_q.supplyOn)
                        state_q <= ST_CHECK;
                ST_CHECK:
                    if (senseSync_q.iovpHigh || iovpFault_q || fltOtp_q)
                        state_q <= ST_STOP;
                    else
                        state_q <= ST_RUN;
                ST_RUN:
                    if ((ovpTrip && ctrl_q.latchOvp) ||
                        (csTrip && ctrl_q.latchCsOtp) ||
                        (ntcTrip && ctrl_q.latchFltOtp))
                        state_q <= ST_LATCH;
                    else if (iovpTrip || ntcTrip)
                        state_q <= ST_STOP;
                    else if (ovpTrip || csTrip)
                        state_q <= ST_DELAY;
                ST_DELAY:
                    if (fdrDone)
                        state_q <= ST_WAIT_FALL;
                ST_WAIT_FALL:
                    if (supplyFallEvt)
                        state_q <= ST_WAIT_ON;
                ST_STOP:
                    if (supplyFallEvt)
                        state_q <= ST_WAIT_ON;
                ST_LATCH:
                    if (latchReset)
                        state_q <= ST_WAIT_ON;
                default:
                    state_q <= ST_WAIT_ON;
            endcase
        end
    end

    // Drives: high side never overlaps a low-side pulse
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lowSideDrive_q <= 1'h0;
            highSideDrive_q <= 1'h0;
            runOut_q <= 1'h0;
            supplyRestart_q <= 1'h0;
        end
        else
        begin
            lowSideDrive_q <= lowSideReq && switchOk;
            highSideDrive_q <= highSideReq && !lowSideReq &&
                !lowSideDrive_q && switchOk && !lowPowerMode;
            runOut_q <= inRun;
            supplyRestart_q <= state_q == ST_STOP;
        end
    end

    // Bias current off above the cut level and in burst-off of light load
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            fltBiasEn_q <= 1'h0;
        else
            fltBiasEn_q <= !senseSync_q.fltAboveBiasCut &&
                !(lightLoad && burstOff);
    end

    a_ovp_to_delay: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ovpTrip && inRun && !ctrl_q.latchOvp && !iovpTrip && !ntcTrip
        |=> state_q == ST_DELAY ##1 !runOut_q)
        else $error("over-voltage did not start recovery delay");
    a_delay_no_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        state_q == ST_DELAY |=> !lowSideDrive_q)
        else $error("low-side pulse during recovery delay");
    a_wait_supply_fall: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        state_q == ST_WAIT_FALL && !supplyFallEvt
        |=> state_q == ST_WAIT_FALL)
        else $error("restart before supply falling event");
    a_input_overvoltage_fault_needs_level: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        iovpTrip |-> $past(senseSync_q.iovpHigh, 2))
        else $error("input over-voltage without high level");
    a_check_first: assert property (@(posedge clk_sys) disable iff (!arst_n)
        state_q == ST_CHECK && senseSync_q.iovpHigh
        |=> state_q == ST_STOP ##1 supplyRestart_q)
        else $error("switching allowed with input over-voltage");
    a_input_overvoltage_fault_release: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        iovpFault_q && !iovpTrip && !senseSync_q.iovpBelowRelease
        |=> iovpFault_q)
        else $error("input over-voltage cleared too early");
    a_bias_cut: assert property (@(posedge clk_sys) disable iff (!arst_n)
        senseSync_q.fltAboveBiasCut || (lightLoad && burstOff)
        |=> !fltBiasEn_q)
        else $error("bias current left on");
    a_thresh_raise: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ntcTrip && !ctrl_q.latchFltOtp |=> ntcThreshHigh_q && fltOtp_q)
        else $error("thermal threshold not raised");
    a_cs_low_side_off: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        $rose(csSeen_q) |-> $past(!lowSideDrive_q))
        else $error("current-sense thermal sampled during on time");
    a_no_overlap: assert property (@(posedge clk_sys) disable iff (!arst_n)
        lowSideDrive_q |-> !highSideDrive_q)
        else $error("high side on during low-side pulse");
    a_hs_low_power: assert property (@(posedge clk_sys) disable iff (!arst_n)
        lowPowerMode |=> !highSideDrive_q)
        else $error("high side on in low-power mode");
    a_latch_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        state_q == ST_LATCH && !latchReset |=> state_q == ST_LATCH)
        else $error("latched fault released without reset event");
    a_fault_gates: assert property (@(posedge clk_sys) disable iff (!arst_n)
        anyFault |=> !lowSideDrive_q && !highSideDrive_q)
        else $error("drive active during fault");
endmodule
`default_nettype wire

//--- testbench/fps_analog_model.sv
// Comparators, supply monitor and external sensing seen by the sequencer
`timescale 1ns/10ps
`default_nettype none
module fps_analog_model (
    // Pin voltages in millivolts, set by the bench
    input wire logic [15:0] vsMv,
    input wire logic [15:0] fltMv,
    input wire logic [15:0] csMv,
    // Supply monitor and line events, set by the bench
    input wire logic vddOn,
    input wire logic vddOff,
    input wire logic vddReset,
    input wire logic zeroCross,
    // Device outputs that steer the analog side
    input wire logic lowSideDrive,
    input wire logic runOut,
    input wire logic ntcThreshHigh,
    // Comparator levels
    output var fps_pkg::fps_sense_type sense
);
    import fps_pkg::*;

    always_comb
    begin
        sense.auxOverVolt = vsMv >= 16'h1194;
        sense.iovpHigh = fltMv > 16'h1194;
        sense.iovpBelowRelease = fltMv < 16'h114E;
        sense.fltAboveBiasCut = fltMv > 16'h09C4;
        sense.fltBelowNtc = fltMv < (ntcThreshHigh ? 16'h047E : 16'h01F4);
        // Sensor is biased from run and gated off while low side is on
        sense.csAboveOtp = runOut && !lowSideDrive && csMv > 16'h04B0;
        sense.supplyOn = vddOn;
        sense.supplyOff = vddOff;
        sense.supplyBelowReset = vddReset;
        sense.lineZeroCross = zeroCross;
    end
endmodule
`default_nettype wire

//--- testbench/fps_fault_sequencer_tb.sv
// Self-checking bench for the fault protection sequencer
`timescale 1ns/10ps
`default_nettype none
module fps_fault_sequencer_tb;
    import fps_pkg::*;
    // Short recovery delay keeps the run brief
    localparam int Fdr = 200;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] vsMv = 16'h0000;
    logic [15:0] fltMv = 16'h07D0;
    logic [15:0] csMv = 16'h0000;
    logic vddOn = 1'b0;
    logic vddOff = 1'b0;
    logic vddReset = 1'b0;
    logic zeroCross = 1'b0;
    logic lowSideReq = 1'b0;
    logic highSideReq = 1'b0;
    logic demagEnd = 1'b0;
    logic burstOff = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h00000000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData_q;
    logic lowSideDrive_q;
    logic highSideDrive_q;
    logic runOut_q;
    logic fltBiasEn_q;
    logic ntcThreshHigh_q;
    logic supplyRestart_q;
    fps_sense_type sense;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] rd;

    always #5 clk_sys = ~clk_sys;

    fps_analog_model i_fps_analog_model (.vsMv(vsMv), .fltMv(fltMv),
        .csMv(csMv), .vddOn(vddOn), .vddOff(vddOff), .vddReset(vddReset),
        .zeroCross(zeroCross), .lowSideDrive(lowSideDrive_q),
        .runOut(runOut_q), .ntcThreshHigh(ntcThreshHigh_q), .sense(sense));

    fps_fault_sequencer #(.FdrCycles(Fdr), .IovpCycles(40), .NtcCycles(20))
    i_fps_fault_sequencer (.clk_sys(clk_sys), .arst_n(arst_n),
        .sense(sense), .lowSideReq(lowSideReq), .highSideReq(highSideReq),
        .demagEnd(demagEnd), .burstOff(burstOff), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData_q(regRdData_q), .lowSideDrive_q(lowSideDrive_q),
        .highSideDrive_q(highSideDrive_q), .runOut_q(runOut_q),
        .fltBiasEn_q(fltBiasEn_q), .ntcThreshHigh_q(ntcThreshHigh_q),
        .supplyRestart_q(supplyRestart_q));

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkB(input string n, input logic e, input logic g);
        chk(n, 32'(e), 32'(g));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic rdReg(input logic [3:0] a);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 rd = regRdData_q;
    endtask

    task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    // Polls the state field; gives up after a bounded number of reads
    task automatic waitState(input fps_state_type s);
        for (int i = 0; i < 60; i++)
        begin
            rdReg(STATUS_ADDR);
            if (rd[2:0] === s)
                return;
        end
        chk("state", 32'(s), 32'(rd[2:0]));
        print_verdict();
    endtask

    task automatic supplyCycle();
        tick(1);
        vddOn <= 1'b0;
        vddOff <= 1'b1;
        tick(6);
        vddOff <= 1'b0;
        vddOn <= 1'b1;
        tick(6);
    endtask

    // One switching period: low-side pulse, high-side pulse, demag end
    task automatic swCycle(input logic expLow, input logic expHigh);
        tick(1);
        lowSideReq <= 1'b1;
        highSideReq <= 1'b1;
        tick(3);
        #1;
        chkB("lowSide", expLow, lowSideDrive_q);
        chkB("highSideDuringLow", 1'b0, highSideDrive_q);
        tick(1);
        lowSideReq <= 1'b0;
        tick(4);
        #1;
        chkB("highSide", expHigh, highSideDrive_q);
        tick(1);
        highSideReq <= 1'b0;
        demagEnd <= 1'b1;
        tick(1);
        demagEnd <= 1'b0;
    endtask

    task automatic ovpTrip();
        vsMv <= 16'h1388;
        swCycle(1'b1, 1'b1);
        swCycle(1'b1, 1'b1);
        #1;
        chkB("runBeforeThird", 1'b1, runOut_q);
        swCycle(1'b1, 1'b1);
        vsMv <= 16'h0000;
    endtask

    task automatic testRegs();
        rdReg(CTRL_ADDR);
        chk("ctrlReset", 32'h00000000, rd);
        rdReg(STATUS_ADDR);
        chk("statusReset", 32'h00000000, rd);
        wrReg(STATUS_ADDR, 32'hFFFFFFFF);
        rdReg(STATUS_ADDR);
        chk("statusReadOnly", 32'h00000000, rd);
        rdReg(4'hC);
        chk("unmapped", 32'h00000000, rd);
    endtask

    task automatic testIovpWait();
        tick(1);
        fltMv <= 16'h11F8;
        tick(60);
        rdReg(STATUS_ADDR);
        chkB("iovpInWait", 1'b1, rd[STAT_INPUT_OVERVOLTAGE_FAULT]);
        chkB("biasCut", 1'b0, fltBiasEn_q);
        vddOn <= 1'b1;
        waitState(ST_STOP);
        chkB("runBlocked", 1'b0, runOut_q);
        fltMv <= 16'h116C;
        tick(10);
        rdReg(STATUS_ADDR);
        chkB("iovpHeld", 1'b1, rd[STAT_INPUT_OVERVOLTAGE_FAULT]);
        fltMv <= 16'h07D0;
        tick(10);
        rdReg(STATUS_ADDR);
        chkB("iovpClear", 1'b0, rd[STAT_INPUT_OVERVOLTAGE_FAULT]);
        supplyCycle();
        waitState(ST_RUN);
        chkB("biasOn", 1'b1, fltBiasEn_q);
    endtask

    task automatic testModes();
        for (int m = 0; m < 5; m++)
        begin
            wrReg(CTRL_ADDR, 32'(m));
            swCycle(1'b1, m < 2);
            burstOff <= 1'b1;
            tick(4);
            #1;
            chkB("biasBurst", m == 0, fltBiasEn_q);
            tick(1);
            burstOff <= 1'b0;
            tick(4);
            #1;
            chkB("biasAfter", 1'b1, fltBiasEn_q);
        end
        wrReg(CTRL_ADDR, 32'h00000000);
    endtask

    task automatic testIovpRun();
        tick(1);
        fltMv <= 16'h11F8;
        tick(30);
        #1;
        chkB("runBeforeIovp", 1'b1, runOut_q);
        tick(20);
        #1;
        chkB("restart", 1'b1, supplyRestart_q);
        chkB("runAfterIovp", 1'b0, runOut_q);
        tick(1);
        fltMv <= 16'h07D0;
        supplyCycle();
        waitState(ST_RUN);
    endtask

    task automatic testFltOtp();
        tick(1);
        fltMv <= 16'h0190;
        tick(15);
        #1;
        chkB("runBeforeOtp", 1'b1, runOut_q);
        tick(15);
        #1;
        chkB("runAfterOtp", 1'b0, runOut_q);
        chkB("threshRaised", 1'b1, ntcThreshHigh_q);
        tick(1);
        fltMv <= 16'h03E8;
        tick(10);
        rdReg(STATUS_ADDR);
        chkB("otpHeld", 1'b1, rd[STAT_FLTOTP]);
        chkB("threshStat", 1'b1, rd[STAT_THRESH]);
        fltMv <= 16'h07D0;
        tick(10);
        #1;
        chkB("threshBack", 1'b0, ntcThreshHigh_q);
        supplyCycle();
        waitState(ST_RUN);
    endtask

    task automatic testOvp();
        ovpTrip();
        tick(4);
        #1;
        chkB("runAfterOvp", 1'b0, runOut_q);
        rdReg(STATUS_ADDR);
        chk("ovpState", 32'(ST_DELAY), 32'(rd[2:0]));
        chkB("ovpFlag", 1'b1, rd[STAT_OVP]);
        swCycle(1'b0, 1'b0);
        tick(Fdr);
        waitState(ST_WAIT_FALL);
        tick(20);
        rdReg(STATUS_ADDR);
        chk("noEarlyStart", 32'(ST_WAIT_FALL), 32'(rd[2:0]));
        supplyCycle();
        waitState(ST_RUN);
    endtask

    task automatic testCsOtp();
        tick(1);
        csMv <= 16'h0514;
        swCycle(1'b1, 1'b1);
        #1;
        chkB("runAfterOne", 1'b1, runOut_q);
        swCycle(1'b1, 1'b1);
        tick(4);
        rdReg(STATUS_ADDR);
        chk("csState", 32'(ST_DELAY), 32'(rd[2:0]));
        chkB("csFlag", 1'b1, rd[STAT_CSOTP]);
        csMv <= 16'h0000;
        tick(Fdr);
        waitState(ST_WAIT_FALL);
        supplyCycle();
        waitState(ST_RUN);
    endtask

    task automatic testLatch();
        // Each latch option once: output, current-sense, thermistor
        for (int k = 0; k < 3; k++)
        begin
            if (k == 0)
            begin
                wrReg(CTRL_ADDR, 32'h00000008);
                ovpTrip();
            end
            else if (k == 1)
            begin
                wrReg(CTRL_ADDR, 32'h00000020);
                csMv <= 16'h0514;
                swCycle(1'b1, 1'b1);
                swCycle(1'b1, 1'b1);
                csMv <= 16'h0000;
            end
            else
            begin
                wrReg(CTRL_ADDR, 32'h00000010);
                tick(1);
                fltMv <= 16'h0190;
                tick(30);
                fltMv <= 16'h07D0;
            end
            tick(5);
            supplyCycle();
            rdReg(STATUS_ADDR);
            chk("latched", 32'(ST_LATCH), 32'(rd[2:0]));
            chkB("latchRun", 1'b0, rd[STAT_RUN]);
            chkB("latchThresh", 1'b0, rd[STAT_THRESH]);
            if (k != 1)
                vddReset <= 1'b1;
            else
                zeroCross <= 1'b1;
            tick(4);
            vddReset <= 1'b0;
            zeroCross <= 1'b0;
            waitState(ST_RUN);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        tick(5);
        arst_n <= 1'b1;
        tick(2);
        testRegs();
        testIovpWait();
        testModes();
        testIovpRun();
        testFltOtp();
        testOvp();
        testCsOtp();
        testLatch();
        print_verdict();
    end
endmodule
`default_nettype wire
